/* rtl/flash_lock_table.sv */
// Individual block and sector lock bits of one die.
`timescale 1ns/1ps
module flash_lock_table (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [9:0] lock_idx_i,
  input wire logic unlock_i,
  input wire logic lock_i,
  output logic locked_o,
  output logic any_locked_o
);
  typedef struct packed {
    logic [flash_wp_pkg::LOCK_BITS-1:0] bits;
  } lock_state_t;

  lock_state_t st;
  lock_state_t next_st;

  always_comb begin
    next_st = st;
    if (unlock_i) begin
      next_st.bits[lock_idx_i] = 1'b0;
    end else if (lock_i) begin
      next_st.bits[lock_idx_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st.bits <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign locked_o = st.bits[lock_idx_i];
  assign any_locked_o = |st.bits;
endmodule // flash_lock_table

/* rtl/flash_spi_rx.sv */
// Serial receiver: synchronises the link pins and assembles instruction bytes.
`timescale 1ns/1ps
module flash_spi_rx (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_di_i,
  flash_frame_if.rx link
);
  typedef struct packed {
    logic [2:0] clk_p;
    logic [2:0] cs_p;
    logic [1:0] di_p;
    logic [6:0] shift;
    logic [2:0] cnt;
    logic byte_valid;
    logic [7:0] byte_data;
    logic frame_start;
    logic frame_end;
    logic sck_fall;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;

  // Stage 0 of each pin feeds only stage 1; edges are found from stages 1 and 2.
  always_comb begin
    next_st = st;
    next_st.byte_valid = 1'b0;
    next_st.frame_start = 1'b0;
    next_st.frame_end = 1'b0;
    next_st.sck_fall = 1'b0;
    next_st.clk_p = {st.clk_p[1:0], spi_clk_i};
    next_st.cs_p = {st.cs_p[1:0], spi_cs_n_i};
    next_st.di_p = {st.di_p[0], spi_di_i};
    if (st.cs_p[2] && !st.cs_p[1]) begin
      next_st.frame_start = 1'b1;
      next_st.cnt = 3'h0;
    end
    if (!st.cs_p[2] && st.cs_p[1]) begin
      next_st.frame_end = 1'b1;
    end
    if (!st.cs_p[1] && !st.cs_p[2]) begin
      if (st.clk_p[1] && !st.clk_p[2]) begin
        next_st.shift = {st.shift[5:0], st.di_p[1]};
        next_st.cnt = st.cnt + 3'h1;
        if (st.cnt == 3'h7) begin
          next_st.byte_valid = 1'b1;
          next_st.byte_data = {st.shift, st.di_p[1]};
        end
      end
      if (!st.clk_p[1] && st.clk_p[2]) begin
        next_st.sck_fall = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
      st.cs_p <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  assign link.frame_start = st.frame_start;
  assign link.frame_end = st.frame_end;
  assign link.byte_valid = st.byte_valid;
  assign link.byte_data = st.byte_data;
  assign link.sck_fall = st.sck_fall;
endmodule // flash_spi_rx

/* rtl/flash_write_protect_status.sv */
// Write-protection, status flags and busy filtering of one serial flash die.
`timescale 1ns/1ps
module flash_write_protect_status #(
  parameter int unsigned PUW_CYCLES = 2000,
  parameter int unsigned PROG_CYCLES = 400,
  parameter int unsigned ERASE_CYCLES = 3000,
  parameter int unsigned WRSR_CYCLES = 200
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_di_i,
  input wire logic die_active_i,
  output logic spi_do_o,
  output logic spi_do_oe_o
);
  typedef struct packed {
    logic act_s1;
    logic act_s2;
    logic [15:0] puw_cnt;
    logic puw_done;
    logic write_enable_latch;
    logic [3:0] bp;
    logic tb;
    logic cmp;
    logic status_lock;
    logic protect_scheme_select;
    logic busy;
    logic [23:0] busy_cnt;
    logic [7:0] op;
    logic [3:0] nbytes;
    logic [31:0] addr;
    logic [7:0] data1;
    logic frame_ok;
    logic [1:0] rd_sel;
    logic [2:0] rd_bit;
    logic do_bit;
    logic do_oe;
    logic unlock_req;
    logic lock_req;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  flash_frame_if link ();
  logic locked;
  logic any_locked;
  logic [9:0] lock_idx;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] sr3;
  logic [7:0] stat;
  logic wr_ok;
  logic sr_ok;
  logic prot;
  logic chip_prot;
  logic go;
  logic [23:0] go_cycles;

  flash_spi_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .spi_clk_i(spi_clk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_di_i(spi_di_i),
    .link(link.rx)
  );

  assign lock_idx = flash_wp_pkg::lock_index(st.addr);

  flash_lock_table u_locks (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .lock_idx_i(lock_idx),
    .unlock_i(st.unlock_req),
    .lock_i(st.lock_req),
    .locked_o(locked),
    .any_locked_o(any_locked)
  );

  always_comb begin
    sr1 = 8'h00;
    sr1[flash_wp_pkg::SR1_BUSY_BIT] = st.busy;
    sr1[flash_wp_pkg::SR1_WEL_BIT] = st.write_enable_latch;
    sr1[flash_wp_pkg::SR1_BP_MSB:flash_wp_pkg::SR1_BP_LSB] = st.bp;
    sr1[flash_wp_pkg::SR1_TB_BIT] = st.tb;
    sr2 = 8'h00;
    sr2[flash_wp_pkg::SR2_SRL_BIT] = st.status_lock;
    sr2[flash_wp_pkg::SR2_CMP_BIT] = st.cmp;
    sr3 = 8'h00;
    sr3[flash_wp_pkg::SR3_WPS_BIT] = st.protect_scheme_select;
    case (st.rd_sel)
      2'h1: stat = sr1;
      2'h2: stat = sr2;
      2'h3: stat = sr3;
      default: stat = 8'h00;
    endcase
  end

  // The scheme select gates which protection source is consulted, never both.
  always_comb begin
    if (st.protect_scheme_select) begin
      prot = locked;
      chip_prot = any_locked;
    end else begin
      prot = flash_wp_pkg::range_protected(st.addr[flash_wp_pkg::BLK_MSB:flash_wp_pkg::BLK_LSB],
                                           st.bp, st.tb, st.cmp);
      chip_prot = (st.bp != 4'h0) || st.cmp;
    end
  end

  assign wr_ok = st.write_enable_latch && st.puw_done;
  assign sr_ok = wr_ok && !st.status_lock;

  always_comb begin
    next_st = st;
    go = 1'b0;
    go_cycles = 24'h000000;
    next_st.unlock_req = 1'b0;
    next_st.lock_req = 1'b0;
    next_st.act_s1 = die_active_i;
    next_st.act_s2 = st.act_s1;

    if (!st.puw_done) begin
      if (st.puw_cnt == 16'h0000) begin
        next_st.puw_done = 1'b1;
      end else begin
        next_st.puw_cnt = st.puw_cnt - 16'h0001;
      end
    end

    // The countdown ignores die activity so a deselected die completes its work.
    if (st.busy) begin
      if (st.busy_cnt == 24'h000000) begin
        next_st.busy = 1'b0;
        next_st.write_enable_latch = 1'b0;
      end else begin
        next_st.busy_cnt = st.busy_cnt - 24'h000001;
      end
    end

    if (link.frame_start) begin
      next_st.nbytes = 4'h0;
      next_st.frame_ok = st.act_s2;
      next_st.rd_sel = 2'h0;
      next_st.rd_bit = 3'h7;
      next_st.do_oe = 1'b0;
    end

    if (link.byte_valid && st.frame_ok) begin
      if (st.nbytes == 4'h0) begin
        next_st.op = link.byte_data;
        if (st.busy && !flash_wp_pkg::busy_allowed(link.byte_data)) begin
          next_st.frame_ok = 1'b0;
        end else begin
          next_st.rd_sel = flash_wp_pkg::read_sel(link.byte_data);
          next_st.do_oe = flash_wp_pkg::read_sel(link.byte_data) != 2'h0;
        end
      end else if (st.nbytes <= flash_wp_pkg::ADDR_BYTES) begin
        next_st.addr = {st.addr[23:0], link.byte_data};
      end
      if (st.nbytes == 4'h1) begin
        next_st.data1 = link.byte_data;
      end
      if (st.nbytes != 4'hF) begin
        next_st.nbytes = st.nbytes + 4'h1;
      end
    end

    // Status is sampled live on every bit, so a polling host sees busy drop.
    if (link.sck_fall && st.rd_sel != 2'h0) begin
      next_st.do_bit = stat[st.rd_bit];
      next_st.rd_bit = st.rd_bit - 3'h1;
    end

    if (link.frame_end) begin
      next_st.do_oe = 1'b0;
      next_st.rd_sel = 2'h0;
      if (st.frame_ok) begin
        case (st.op)
          flash_wp_pkg::OP_WR_ENABLE: begin
            if (st.nbytes == 4'h1 && st.puw_done) begin
              next_st.write_enable_latch = 1'b1;
            end
          end
          flash_wp_pkg::OP_WR_DISABLE: begin
            if (st.nbytes == 4'h1) begin
              next_st.write_enable_latch = 1'b0;
            end
          end
          flash_wp_pkg::OP_WR_SR1: begin
            if (st.nbytes == 4'h2 && sr_ok) begin
              next_st.bp = st.data1[flash_wp_pkg::SR1_BP_MSB:flash_wp_pkg::SR1_BP_LSB];
              next_st.tb = st.data1[flash_wp_pkg::SR1_TB_BIT];
              go = 1'b1;
              go_cycles = 24'(WRSR_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_WR_SR2: begin
            if (st.nbytes == 4'h2 && sr_ok) begin
              next_st.status_lock = st.data1[flash_wp_pkg::SR2_SRL_BIT];
              next_st.cmp = st.data1[flash_wp_pkg::SR2_CMP_BIT];
              go = 1'b1;
              go_cycles = 24'(WRSR_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_WR_SR3: begin
            if (st.nbytes == 4'h2 && sr_ok) begin
              next_st.protect_scheme_select = st.data1[flash_wp_pkg::SR3_WPS_BIT];
              go = 1'b1;
              go_cycles = 24'(WRSR_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_PROG, flash_wp_pkg::OP_QPROG: begin
            if (st.nbytes > flash_wp_pkg::ADDR_BYTES && wr_ok && !prot) begin
              go = 1'b1;
              go_cycles = 24'(PROG_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_SEC_ERASE, flash_wp_pkg::OP_BLK_ERASE: begin
            if (st.nbytes == flash_wp_pkg::ADDR_BYTES + 4'h1 && wr_ok && !prot) begin
              go = 1'b1;
              go_cycles = 24'(ERASE_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_CHIP_ERASE, flash_wp_pkg::OP_CHIP_ERASE_ALT: begin
            if (st.nbytes == 4'h1 && wr_ok && !chip_prot) begin
              go = 1'b1;
              go_cycles = 24'(ERASE_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_SECR_ERASE: begin
            if (st.nbytes == flash_wp_pkg::ADDR_BYTES + 4'h1 && wr_ok) begin
              go = 1'b1;
              go_cycles = 24'(ERASE_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_SECR_PROG: begin
            if (st.nbytes > flash_wp_pkg::ADDR_BYTES && wr_ok) begin
              go = 1'b1;
              go_cycles = 24'(PROG_CYCLES - 1);
            end
          end
          flash_wp_pkg::OP_UNLOCK: begin
            if (st.nbytes == flash_wp_pkg::ADDR_BYTES + 4'h1 && wr_ok) begin
              next_st.unlock_req = 1'b1;
              next_st.write_enable_latch = 1'b0;
            end
          end
          flash_wp_pkg::OP_LOCK: begin
            if (st.nbytes == flash_wp_pkg::ADDR_BYTES + 4'h1 && wr_ok) begin
              next_st.lock_req = 1'b1;
              next_st.write_enable_latch = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (go) begin
      next_st.busy = 1'b1;
      next_st.busy_cnt = go_cycles;
    end
  end

  // Reset stands for power-on: every die-local setting returns to its default.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
      st.puw_cnt <= 16'(PUW_CYCLES - 1);
      st.write_enable_latch <= flash_wp_pkg::WEL_RESET;
      st.bp <= flash_wp_pkg::BP_RESET;
      st.tb <= flash_wp_pkg::TB_RESET;
      st.cmp <= flash_wp_pkg::CMP_RESET;
      st.status_lock <= flash_wp_pkg::SRL_RESET;
      st.protect_scheme_select <= flash_wp_pkg::WPS_RESET;
      st.rd_bit <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  assign spi_do_o = st.do_bit;
  assign spi_do_oe_o = st.do_oe;
endmodule // flash_write_protect_status

/* shared/flash_frame_if.sv */
// Byte and frame events passed from the serial receiver to the die core.
`timescale 1ns/1ps
interface flash_frame_if;
  logic frame_start;
  logic frame_end;
  logic byte_valid;
  logic [7:0] byte_data;
  logic sck_fall;
  modport rx (output frame_start, output frame_end, output byte_valid, output byte_data, output sck_fall);
  modport core (input frame_start, input frame_end, input byte_valid, input byte_data, input sck_fall);
endinterface

/* shared/flash_wp_pkg.sv */
// Shared constants, field layouts and helper functions for the flash write-protection block.
package flash_wp_pkg;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_RD_SR3 = 8'h15;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_SEC_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_SECR_ERASE = 8'h44;
  localparam logic [7:0] OP_SECR_PROG = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;

  localparam int SR1_BUSY_BIT = 0;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_BP_LSB = 2;
  localparam int SR1_BP_MSB = 5;
  localparam int SR1_TB_BIT = 6;
  localparam int SR2_SRL_BIT = 0;
  localparam int SR2_CMP_BIT = 6;
  localparam int SR3_WPS_BIT = 2;

  localparam logic [3:0] BP_RESET = 4'h0;
  localparam logic TB_RESET = 1'b0;
  localparam logic CMP_RESET = 1'b0;
  localparam logic SRL_RESET = 1'b0;
  localparam logic WPS_RESET = 1'b0;
  localparam logic WEL_RESET = 1'b0;

  localparam logic [3:0] ADDR_BYTES = 4'h4;
  localparam int BLK_MSB = 24;
  localparam int BLK_LSB = 16;
  localparam int SEC_MSB = 15;
  localparam int SEC_LSB = 12;
  localparam logic [8:0] TOP_BLOCK = 9'h1FF;
  localparam logic [9:0] BLOCK_COUNT = 10'h200;
  localparam logic [9:0] LOCK_BLOCKS = 10'h1FE;
  localparam logic [9:0] LOCK_SECTORS = 10'h020;
  localparam int LOCK_BITS = 542;
  localparam logic [3:0] BP_FULL = 4'hA;

  // Read opcodes return 1..3 for the status byte they shift out, 0 otherwise.
  function automatic logic [1:0] read_sel(input logic [7:0] op);
    case (op)
      OP_RD_SR1: read_sel = 2'h1;
      OP_RD_SR2: read_sel = 2'h2;
      OP_RD_SR3: read_sel = 2'h3;
      default: read_sel = 2'h0;
    endcase
  endfunction

  function automatic logic busy_allowed(input logic [7:0] op);
    busy_allowed = (read_sel(op) != 2'h0) || (op == OP_SUSPEND);
  endfunction

  // Blocks 1..510 own one bit each; the two end blocks own sixteen sector bits each.
  function automatic logic [9:0] lock_index(input logic [31:0] a);
    logic [8:0] blk;
    blk = a[BLK_MSB:BLK_LSB];
    if (blk == 9'h000) begin
      lock_index = LOCK_BLOCKS + {6'h00, a[SEC_MSB:SEC_LSB]};
    end else if (blk == TOP_BLOCK) begin
      lock_index = LOCK_BLOCKS + (LOCK_SECTORS >> 1) + {6'h00, a[SEC_MSB:SEC_LSB]};
    end else begin
      lock_index = {1'b0, blk} - 10'h001;
    end
  endfunction

  function automatic logic range_protected(input logic [8:0] blk, input logic [3:0] bp,
                                           input logic tb, input logic cmp);
    logic [9:0] span;
    logic hit;
    if (bp == 4'h0) begin
      span = 10'h000;
    end else if (bp >= BP_FULL) begin
      span = BLOCK_COUNT;
    end else begin
      span = 10'h001 << (bp - 4'h1);
    end
    hit = tb ? ({1'b0, blk} < span) : ({1'b0, blk} >= (BLOCK_COUNT - span));
    range_protected = hit ^ cmp;
  endfunction
endpackage

/* tb/flash_host_model.sv */
// Behavioural SPI host that frames instructions and captures status bytes.
`timescale 1ns/1ps
module flash_host_model (
  input wire logic clk_sys_i,
  input wire logic spi_do_i,
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_di_o
);
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_di_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Mode 0, 80 ns link period; the clock stands low between frames.
  task automatic xfer(input logic [39:0] d, input int nb, input int nrd, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    spi_cs_n_o = 1'b0;
    tick(8);
    for (i = 0; i < 8 * (nb + nrd); i++) begin
      // Read phases toggle DI so the device never sees a steady stale value.
      spi_di_o = (i < 8 * nb) ? d[39 - i] : ~spi_di_o;
      tick(8);
      rd = {rd[6:0], spi_do_i};
      spi_clk_o = 1'b1;
      tick(8);
      spi_clk_o = 1'b0;
    end
    tick(8);
    spi_cs_n_o = 1'b1;
    spi_di_o = ~spi_di_o;
    tick(8);
  endtask
endmodule // flash_host_model

/* tb/flash_wp_checker.sv */
// Port-level assertions for the flash write-protection block.
`timescale 1ns/1ps
module flash_wp_checker (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_di_i,
  input wire logic die_active_i,
  input wire logic spi_do_o,
  input wire logic spi_do_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_out_reset; $fell(srst_i) |-> !spi_do_oe_o && !spi_do_o; endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not quiet after reset");

  property p_oe_idle; spi_cs_n_i [*8] |-> !spi_do_oe_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected");

  property p_oe_start; $rose(spi_do_oe_o) |-> !spi_cs_n_i && !$past(spi_cs_n_i, 8); endproperty
  a_oe_start: assert property (p_oe_start) else $error("output enabled outside a frame");

  property p_oe_hold; spi_do_oe_o && !spi_cs_n_i |=> spi_do_oe_o; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output enable dropped inside a frame");

  property p_oe_drop; $rose(spi_cs_n_i) |-> ##[1:6] !spi_do_oe_o; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("output enable stuck after deselect");

  property p_do_clk_high; spi_clk_i [*8] |-> $stable(spi_do_o); endproperty
  a_do_clk_high: assert property (p_do_clk_high) else $error("data out moved while clock high");

  property p_do_idle; (spi_cs_n_i && !spi_clk_i) [*8] |-> $stable(spi_do_o); endproperty
  a_do_idle: assert property (p_do_idle) else $error("data out moved while idle");

  // Shifts are launched by a falling link clock, so a change needs a recent high phase.
  property p_do_after_fall;
    $changed(spi_do_o) && spi_do_oe_o && !spi_cs_n_i |-> !spi_clk_i && $past(spi_clk_i, 6);
  endproperty
  a_do_after_fall: assert property (p_do_after_fall) else $error("data out moved off the falling edge");
endmodule // flash_wp_checker

/* tb/test_flash_write_protect_status.sv */
// Self-checking bench for the flash write-protection block.
`timescale 1ns/1ps
module test_flash_write_protect_status;
  typedef struct {logic wren; logic die; logic [39:0] d; int nb; int wt; logic [7:0] exp;} row_t;
  row_t rows[$];
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic die_active = 1'b1;
  logic [7:0] v;
  wire spi_clk;
  wire spi_cs_n;
  wire spi_di;
  wire spi_do;
  wire spi_do_oe;
  wire spi_miso;
  int err_total = 0;
  int checked = 0;

  // Counts are sized so that busy periods outlast a status read.
  flash_write_protect_status #(.PROG_CYCLES(2000),
    .WRSR_CYCLES(1500)) DUT (.clk_sys_i(clk_sys), .srst_i(srst), .spi_clk_i(spi_clk),
    .spi_cs_n_i(spi_cs_n), .spi_di_i(spi_di), .die_active_i(die_active), .spi_do_o(spi_do),
    .spi_do_oe_o(spi_do_oe));
  // An undriven data line shows the inverse of the last bit, so a read taken while released fails.
  assign spi_miso = spi_do_oe ? spi_do : ~spi_do;
  flash_host_model host (.clk_sys_i(clk_sys), .spi_do_i(spi_miso), .spi_clk_o(spi_clk),
    .spi_cs_n_o(spi_cs_n), .spi_di_o(spi_di));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] val);
    host.xfer({op, 32'h0000_0000}, 1, 1, val);
  endtask

  task automatic add(input logic w, input logic dv, input logic [39:0] d, input int nb, input int wt,
                     input logic [7:0] e);
    rows.push_back('{w, dv, d, nb, wt, e});
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end

  initial begin
    add(0, 1, 40'h06_0000_0000, 1, 0, 8'h02);
    add(0, 1, 40'h04_0000_0000, 1, 0, 8'h00);
    add(1, 1, 40'h02_0010_0000, 5, 0, 8'h03);
    add(0, 1, 40'h04_0000_0000, 1, 0, 8'h03);
    add(0, 1, 40'h75_0000_0000, 1, 0, 8'h03);
    add(0, 1, 40'h00_0000_0000, 0, 2000, 8'h00);
    add(0, 1, 40'h02_0010_0000, 5, 0, 8'h00);
    add(1, 1, 40'h01_5C00_0000, 2, 0, 8'h5F);
    add(0, 1, 40'h00_0000_0000, 0, 1500, 8'h5C);
    add(1, 1, 40'h02_0000_0000, 5, 0, 8'h5E);
    add(0, 1, 40'hC7_0000_0000, 1, 0, 8'h5E);
    add(0, 1, 40'h02_01FF_0000, 5, 0, 8'h5F);
    add(0, 1, 40'h00_0000_0000, 0, 2000, 8'h5C);
    add(1, 1, 40'h31_4000_0000, 2, 1500, 8'h5C);
    add(1, 1, 40'h02_0000_0000, 5, 0, 8'h5F);
    add(0, 1, 40'h00_0000_0000, 0, 2000, 8'h5C);
    add(1, 1, 40'h02_01FF_0000, 5, 0, 8'h5E);
    add(1, 1, 40'h11_0400_0000, 2, 1500, 8'h5C);
    add(1, 1, 40'h02_0005_0000, 5, 0, 8'h5E);
    add(0, 1, 40'h39_0005_0000, 5, 0, 8'h5C);
    add(1, 1, 40'h02_0005_0000, 5, 0, 8'h5F);
    add(0, 0, 40'h06_0000_0000, 1, 2000, 8'h5C);
    add(1, 1, 40'h39_01FF_0000, 5, 0, 8'h5C);
    add(1, 1, 40'h02_01FF_0000, 5, 0, 8'h5F);
    add(0, 1, 40'h00_0000_0000, 0, 2000, 8'h5C);
    add(1, 1, 40'h36_0005_0000, 5, 0, 8'h5C);
    add(1, 1, 40'h20_0005_0000, 5, 0, 8'h5E);
    add(0, 1, 40'h60_0000_0000, 1, 0, 8'h5E);
    add(0, 1, 40'hD8_01FF_0000, 5, 0, 8'h5F);
    add(0, 1, 40'h00_0000_0000, 0, 3000, 8'h5C);
    add(1, 1, 40'h32_01FF_0000, 5, 2000, 8'h5C);
    add(1, 1, 40'h42_0000_0000, 5, 2000, 8'h5C);
    add(1, 1, 40'h44_0000_0000, 5, 3000, 8'h5C);
    add(1, 1, 40'h31_4100_0000, 2, 1500, 8'h5C);
    add(1, 1, 40'h01_0000_0000, 2, 0, 8'h5E);
    repeat (16) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    host.tick(4);
    // Sent well inside the power-up window, so it must leave no trace.
    host.xfer(40'h06_0000_0000, 1, 0, v);
    rd(flash_wp_pkg::OP_RD_SR1, v);
    check("sr1 early wren", v, 8'h00);
    check("oe idle", {7'h00, spi_do_oe}, 8'h00);
    host.tick(1700);
    foreach (rows[i]) begin
      die_active = rows[i].die;
      host.tick(4);
      if (rows[i].wren) begin
        host.xfer(40'h06_0000_0000, 1, 0, v);
      end
      if (rows[i].nb > 0) begin
        host.xfer(rows[i].d, rows[i].nb, 0, v);
      end
      host.tick(rows[i].wt);
      die_active = 1'b1;
      host.tick(4);
      rd(flash_wp_pkg::OP_RD_SR1, v);
      check("sr1 row", v, rows[i].exp);
    end
    rd(flash_wp_pkg::OP_RD_SR2, v);
    check("sr2 complement", v, 8'h41);
    rd(flash_wp_pkg::OP_RD_SR3, v);
    check("sr3 scheme", v, 8'h04);
    srst = 1'b1;
    host.tick(16);
    srst = 1'b0;
    host.tick(4);
    rd(flash_wp_pkg::OP_RD_SR1, v);
    check("sr1 after reset", v, 8'h00);
    rd(flash_wp_pkg::OP_RD_SR2, v);
    check("sr2 after reset", v, 8'h00);
    rd(flash_wp_pkg::OP_RD_SR3, v);
    check("sr3 after reset", v, 8'h00);
    complete_run();
  end
endmodule // test_flash_write_protect_status

bind flash_write_protect_status flash_wp_checker chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i), .spi_di_i(spi_di_i), .die_active_i(die_active_i),
  .spi_do_o(spi_do_o), .spi_do_oe_o(spi_do_oe_o));
